/* File: hdl/bbf_core.sv */
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module bbf_core (
	// Clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	// Write address channel
	input wire logic [bbf_pkg::AXI_AW-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	// Write data channel
	input wire logic [bbf_pkg::AXI_DW-1:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	// Write response channel
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// Read address channel
	input wire logic [bbf_pkg::AXI_AW-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	// Read data channel
	output logic [bbf_pkg::AXI_DW-1:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);
	// Latched write request
	logic [bbf_pkg::AXI_AW-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	// Architectural state
	logic [31:0] cmd; // Last accepted command word
	logic [15:0] pc; // Program counter
	logic [7:0] flags; // processor_flags_register
	logic [7:0] result; // Data from host reads
	logic [1:0] last_cycles; // Execute cycles of last op
	logic bad; // Last command had unknown code
	bbf_pkg::bbf_state_t state;
	// Command decode
	bbf_pkg::bbf_op_t op;
	logic [2:0] bsel;
	logic [15:0] k_ext;
	logic [7:0] opnd;
	logic idle, ex, ex2, write_fire, start;
	logic cmd_wr, pc_wr, fl_wr, wr_hit;
	logic is_branch, br_cond, known;
	logic [31:0] merged, rd_mux;
	// Next values from the execute logic
	logic [15:0] next_pc;
	logic [7:0] next_flags, next_result, sh_res;
	logic sh_c;

	// Storage ports
	bbf_mem_if #(.AW(bbf_pkg::GPR_AW), .DW(bbf_pkg::DW)) gpr ();
	bbf_mem_if #(.AW(bbf_pkg::IO_AW), .DW(bbf_pkg::DW)) io ();

	// Working registers
	bbf_mem #(.AW(bbf_pkg::GPR_AW), .DW(bbf_pkg::DW)) u_gpr (
		.clk(CLK),
		.arst_n(ARST_N),
		.port(gpr.store)
	);
	// I/O space
	bbf_mem #(.AW(bbf_pkg::IO_AW), .DW(bbf_pkg::DW)) u_io (
		.clk(CLK),
		.arst_n(ARST_N),
		.port(io.store)
	);

	// Field extraction
	assign op = bbf_pkg::bbf_op_t'(cmd[bbf_pkg::OP_LSB +: bbf_pkg::OP_W]);
	assign bsel = cmd[bbf_pkg::BIT_LSB +: bbf_pkg::BIT_W];
	assign k_ext = {{(bbf_pkg::PC_W - bbf_pkg::K_W){cmd[bbf_pkg::K_LSB +
		bbf_pkg::K_W - 1]}}, cmd[bbf_pkg::K_LSB +: bbf_pkg::K_W]};
	assign opnd = gpr.rdata;
	assign gpr.addr = cmd[bbf_pkg::RD_LSB +: bbf_pkg::GPR_AW];
	assign io.addr = cmd[bbf_pkg::PORT_LSB +: bbf_pkg::IO_AW];
	assign idle = (state == bbf_pkg::ST_IDLE);
	assign ex = (state == bbf_pkg::ST_EXEC);
	assign ex2 = (state == bbf_pkg::ST_EXEC2);

	// Both halves of a write held and no response pending
	assign write_fire = !AWREADY && !WREADY && !BVALID;
	assign cmd_wr = (aw_addr == bbf_pkg::OFS_CMD);
	assign pc_wr = (aw_addr == bbf_pkg::OFS_PC);
	assign fl_wr = (aw_addr == bbf_pkg::OFS_FLAGS);
	assign wr_hit = cmd_wr || pc_wr || fl_wr ||
		(aw_addr == bbf_pkg::OFS_STATUS);
	// Writes while busy are dropped so a running op never sees a torn state
	assign start = write_fire && cmd_wr && idle;

	// Byte-strobe merge onto the addressed register
	always_comb begin
		logic [31:0] old;
		old = '0;
		if (cmd_wr) begin
			old = cmd;
		end else if (pc_wr) begin
			old = {16'h0000, pc};
		end else if (fl_wr) begin
			old = {24'h000000, flags};
		end
		for (int i = 0; i < 4; i++) begin
			merged[i*8 +: 8] = w_strb[i] ? w_data[i*8 +: 8] : old[i*8 +: 8];
		end
	end

	// Write address, data and response channels
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			AWREADY <= 1'b1;
			WREADY <= 1'b1;
			BVALID <= 1'b0;
			BRESP <= bbf_pkg::RESP_OKAY;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end else begin
			// Address and data may arrive in either order
			if (AWVALID && AWREADY) begin
				aw_addr <= AWADDR;
				AWREADY <= 1'b0;
			end
			if (WVALID && WREADY) begin
				w_data <= WDATA;
				w_strb <= WSTRB;
				WREADY <= 1'b0;
			end
			if (write_fire) begin
				BVALID <= 1'b1;
				BRESP <= wr_hit ? bbf_pkg::RESP_OKAY : bbf_pkg::RESP_SLVERR;
			end else if (BVALID && BREADY) begin
				BVALID <= 1'b0;
				AWREADY <= 1'b1;
				WREADY <= 1'b1;
			end
		end
	end

	// Read data selection
	always_comb begin
		rd_mux = '0;
		case (ARADDR)
			bbf_pkg::OFS_CMD: rd_mux = cmd;
			bbf_pkg::OFS_PC: rd_mux = {16'h0000, pc};
			bbf_pkg::OFS_FLAGS: rd_mux = {24'h000000, flags};
			bbf_pkg::OFS_STATUS: begin
				rd_mux[bbf_pkg::ST_BUSY] = !idle;
				rd_mux[bbf_pkg::ST_BAD] = bad;
				rd_mux[bbf_pkg::ST_CYC_LSB +: 2] = last_cycles;
				rd_mux[bbf_pkg::ST_RES_LSB +: 8] = result;
			end
			default: rd_mux = '0;
		endcase
	end

	// Read address and data channels, answer one edge after the handshake
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ARREADY <= 1'b1;
			RVALID <= 1'b0;
			RDATA <= '0;
			RRESP <= bbf_pkg::RESP_OKAY;
		end else if (ARVALID && ARREADY) begin
			ARREADY <= 1'b0;
			RVALID <= 1'b1;
			RDATA <= rd_mux;
			RRESP <= (ARADDR == bbf_pkg::OFS_CMD ||
				ARADDR == bbf_pkg::OFS_PC ||
				ARADDR == bbf_pkg::OFS_FLAGS ||
				ARADDR == bbf_pkg::OFS_STATUS) ?
				bbf_pkg::RESP_OKAY : bbf_pkg::RESP_SLVERR;
		end else if (RVALID && RREADY) begin
			RVALID <= 1'b0;
			ARREADY <= 1'b1;
		end
	end

	// Branch condition decode
	always_comb begin
		is_branch = 1'b1;
		br_cond = 1'b0;
		case (op)
			bbf_pkg::OP_BRANCH_TRANSFER_CLEAR: br_cond = !flags[bbf_pkg::FL_T];
			bbf_pkg::OP_BRANCH_OVERFLOW_SET: br_cond = flags[bbf_pkg::FL_V];
			bbf_pkg::OP_BRANCH_OVERFLOW_CLEAR: br_cond = !flags[bbf_pkg::FL_V];
			bbf_pkg::OP_BRANCH_IRQ_ENABLED: br_cond = flags[bbf_pkg::FL_I];
			bbf_pkg::OP_BRANCH_IRQ_DISABLED: br_cond = !flags[bbf_pkg::FL_I];
			default: is_branch = 1'b0;
		endcase
	end

	// Shift and rotate unit, old carry feeds the rotates
	always_comb begin
		sh_res = opnd;
		sh_c = opnd[0];
		case (op)
			bbf_pkg::OP_SHIFT_LEFT_LOGICAL: {sh_c, sh_res} = {opnd, 1'b0};
			bbf_pkg::OP_SHIFT_RIGHT_LOGICAL: sh_res = {1'b0, opnd[7:1]};
			bbf_pkg::OP_ROTATE_LEFT_CARRY:
				{sh_c, sh_res} = {opnd, flags[bbf_pkg::FL_C]};
			bbf_pkg::OP_ROTATE_RIGHT_CARRY:
				sh_res = {flags[bbf_pkg::FL_C], opnd[7:1]};
			bbf_pkg::OP_SHIFT_RIGHT_ARITH: sh_res = {opnd[7], opnd[7:1]};
			default: sh_res = opnd;
		endcase
	end

	// Execute step: flags, program counter and storage writes
	always_comb begin
		next_pc = pc;
		next_flags = flags;
		next_result = result;
		known = 1'b1;
		gpr.we = 1'b0;
		gpr.wdata = opnd;
		io.we = 1'b0;
		io.wdata = result;
		if (ex2) begin
			// second cycle commits the I/O write
			io.we = !is_branch;
			// taken branch lands after two cycles
			next_pc = is_branch ? 16'(pc + bbf_pkg::PC_STEP + k_ext) :
				16'(pc + bbf_pkg::PC_STEP);
		end else if (ex) begin
			next_pc = 16'(pc + bbf_pkg::PC_STEP);
			case (op)
				bbf_pkg::OP_IO_BIT_SET, bbf_pkg::OP_IO_BIT_CLEAR: begin
					next_pc = pc;
					next_result = io.rdata;
					next_result[bsel] = (op == bbf_pkg::OP_IO_BIT_SET);
				end
				bbf_pkg::OP_SHIFT_LEFT_LOGICAL, bbf_pkg::OP_SHIFT_RIGHT_LOGICAL,
				bbf_pkg::OP_ROTATE_LEFT_CARRY, bbf_pkg::OP_ROTATE_RIGHT_CARRY,
				bbf_pkg::OP_SHIFT_RIGHT_ARITH: begin
					// Z and N from the result, C from the bit shifted out, V is N xor C
					gpr.we = 1'b1;
					gpr.wdata = sh_res;
					next_flags[bbf_pkg::FL_Z] = (sh_res == 8'h00);
					next_flags[bbf_pkg::FL_C] = sh_c;
					next_flags[bbf_pkg::FL_N] = sh_res[7];
					next_flags[bbf_pkg::FL_V] = sh_res[7] ^ sh_c;
				end
				bbf_pkg::OP_NIBBLE_SWAP: begin
					gpr.we = 1'b1;
					gpr.wdata = {opnd[3:0], opnd[7:4]};
				end
				bbf_pkg::OP_BIT_TO_TRANSFER_FLAG: begin
					next_flags[bbf_pkg::FL_T] = opnd[bsel];
				end
				bbf_pkg::OP_TRANSFER_FLAG_TO_BIT: begin
					gpr.we = 1'b1;
					gpr.wdata[bsel] = flags[bbf_pkg::FL_T];
				end
				bbf_pkg::OP_FLAG_SET_INDEXED: next_flags[bsel] = 1'b1;
				bbf_pkg::OP_FLAG_CLEAR_INDEXED: next_flags[bsel] = 1'b0;
				bbf_pkg::OP_HOST_GPR_WRITE: begin
					next_pc = pc;
					gpr.we = 1'b1;
					gpr.wdata = cmd[bbf_pkg::DATA_LSB +: 8];
				end
				bbf_pkg::OP_HOST_IO_WRITE: begin
					next_pc = pc;
					io.we = 1'b1;
					io.wdata = cmd[bbf_pkg::DATA_LSB +: 8];
				end
				bbf_pkg::OP_HOST_GPR_READ: begin
					next_pc = pc;
					next_result = opnd;
				end
				bbf_pkg::OP_HOST_IO_READ: begin
					next_pc = pc;
					next_result = io.rdata;
				end
				default: begin
					known = is_branch;
					if (!is_branch) begin
						next_pc = pc;
					end else if (br_cond) begin
						next_pc = pc;
					end
				end
			endcase
		end
	end

	// Sequencer: fetch operands, then one or two execute cycles
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state <= bbf_pkg::ST_IDLE;
			last_cycles <= '0;
		end else begin
			case (state)
				bbf_pkg::ST_IDLE: begin
					if (start) begin
						state <= bbf_pkg::ST_FETCH;
					end
				end
				// Storage read data is registered, so wait one edge
				bbf_pkg::ST_FETCH: state <= bbf_pkg::ST_EXEC;
				bbf_pkg::ST_EXEC: begin
					if ((is_branch && br_cond) ||
						op == bbf_pkg::OP_IO_BIT_SET ||
						op == bbf_pkg::OP_IO_BIT_CLEAR) begin
						state <= bbf_pkg::ST_EXEC2;
					end else begin
						state <= bbf_pkg::ST_IDLE;
						last_cycles <= bbf_pkg::CYC_ONE;
					end
				end
				bbf_pkg::ST_EXEC2: begin
					state <= bbf_pkg::ST_IDLE;
					last_cycles <= bbf_pkg::CYC_TWO;
				end
				default: state <= bbf_pkg::ST_IDLE;
			endcase
		end
	end

	// Command word, loaded only when the sequencer is free
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cmd <= '0;
		end else if (start) begin
			cmd <= merged;
		end
	end

	// Program counter and flags, software writes only while idle
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pc <= bbf_pkg::PC_RST;
			flags <= bbf_pkg::FLAGS_RST;
		end else if (idle) begin
			if (write_fire && pc_wr) begin
				pc <= merged[15:0];
			end
			if (write_fire && fl_wr) begin
				flags <= merged[7:0];
			end
		end else begin
			pc <= next_pc;
			flags <= next_flags;
		end
	end

	// Host result byte and unknown-code flag
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			result <= '0;
			bad <= 1'b0;
		end else begin
			result <= next_result;
			if (ex) begin
				bad <= !known;
			end
		end
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);

	tclear_branch_a: assert property (
		ex && op == bbf_pkg::OP_BRANCH_TRANSFER_CLEAR && !flags[bbf_pkg::FL_T]
		|=> ex2 ##1 pc == 16'($past(pc, 2) + bbf_pkg::PC_STEP +
		$past(k_ext, 2))) else $error("transfer-clear branch target wrong");
	vset_branch_a: assert property (
		ex && op == bbf_pkg::OP_BRANCH_OVERFLOW_SET && flags[bbf_pkg::FL_V]
		|=> ex2 ##1 idle && last_cycles == bbf_pkg::CYC_TWO)
		else $error("overflow-set branch not two cycles");
	vclear_flags_a: assert property (
		ex && op == bbf_pkg::OP_BRANCH_OVERFLOW_CLEAR && !flags[bbf_pkg::FL_V]
		|=> ex2 && $stable(flags) ##1 $stable(flags))
		else $error("overflow-clear branch disturbed flags");
	irq_branch_a: assert property (
		ex && (op == bbf_pkg::OP_BRANCH_IRQ_ENABLED) == flags[bbf_pkg::FL_I]
		&& (op == bbf_pkg::OP_BRANCH_IRQ_ENABLED ||
		op == bbf_pkg::OP_BRANCH_IRQ_DISABLED) |=> ex2)
		else $error("interrupt branch not taken");
	untaken_step_a: assert property (
		ex && is_branch && !br_cond |=> idle &&
		pc == 16'($past(pc) + bbf_pkg::PC_STEP) &&
		last_cycles == bbf_pkg::CYC_ONE) else $error("untaken branch wrong");
	io_set_a: assert property (
		ex && op == bbf_pkg::OP_IO_BIT_SET |=> io.we &&
		io.wdata == ($past(io.rdata) | 8'(8'h01 << $past(bsel))) &&
		$stable(flags) ##1 last_cycles == bbf_pkg::CYC_TWO)
		else $error("I/O bit set wrong");
	io_clear_a: assert property (
		ex && op == bbf_pkg::OP_IO_BIT_CLEAR |=> io.we &&
		io.wdata == ($past(io.rdata) & ~8'(8'h01 << $past(bsel))))
		else $error("I/O bit clear wrong");
	shift_left_a: assert property (
		ex && op == bbf_pkg::OP_SHIFT_LEFT_LOGICAL |-> gpr.we &&
		gpr.wdata == {opnd[6:0], 1'b0} ##1
		flags[bbf_pkg::FL_C] == $past(opnd[7])) else $error("left shift wrong");
	rotate_right_a: assert property (
		ex && op == bbf_pkg::OP_ROTATE_RIGHT_CARRY |-> gpr.wdata ==
		{flags[bbf_pkg::FL_C], opnd[7:1]} ##1
		flags[bbf_pkg::FL_C] == $past(opnd[0])) else $error("rotate right wrong");
	arith_shift_a: assert property (
		ex && op == bbf_pkg::OP_SHIFT_RIGHT_ARITH |-> gpr.wdata[7] == opnd[7]
		&& gpr.wdata[6:0] == opnd[7:1]) else $error("arith shift wrong");
	bit_store_a: assert property (
		ex && op == bbf_pkg::OP_BIT_TO_TRANSFER_FLAG |=>
		flags[bbf_pkg::FL_T] == $past(opnd[bsel]) &&
		flags[5:0] == $past(flags[5:0])) else $error("bit store wrong");
	flag_set_a: assert property (
		ex && op == bbf_pkg::OP_FLAG_SET_INDEXED |=> flags[$past(bsel)])
		else $error("flag set failed");
	nibble_swap_a: assert property (
		ex && op == bbf_pkg::OP_NIBBLE_SWAP |-> gpr.wdata ==
		{opnd[3:0], opnd[7:4]}) else $error("nibble swap wrong");

	branch_taken_c: cover property (ex && is_branch && br_cond ##1 ex2);
	io_op_c: cover property (ex2 && io.we);
	rotate_c: cover property (ex && op == bbf_pkg::OP_ROTATE_LEFT_CARRY);
	busy_write_c: cover property (write_fire && cmd_wr && !idle);
endmodule

/* File: include/bbf_pkg.sv */
// Summary of operation
// - Branch when transfer flag clear, PC+k+1
// - Branch when overflow set, PC+k+1
// - Branch when overflow clear, flags unchanged
// - Branch when interrupts enabled, flags unchanged
// - Branch when interrupts disabled, flags unchanged
// - Set I/O bit, two cycles, flags kept
// - Clear I/O bit, two cycles, flags kept
// - Left shift, zero fill, ZCNV updated
// - Right shift, zero fill, ZCNV updated
// - Rotate left through carry, ZCNV updated
// - Rotate right through carry, ZCNV updated
// - Arithmetic right shift keeps sign bit
// - Copy register bit into transfer flag
// - Copy transfer flag into register bit
// - Set any single flag, one cycle
// - Clear any single flag, one cycle
package bbf_pkg;
	// Bus geometry
	localparam int AXI_AW = 8;
	localparam int AXI_DW = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Register byte offsets
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_PC = 8'h04;
	localparam logic [7:0] OFS_FLAGS = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	// Command word fields
	localparam int OP_LSB = 0;
	localparam int OP_W = 5;
	localparam int BIT_LSB = 5;
	localparam int BIT_W = 3;
	localparam int RD_LSB = 8;
	localparam int PORT_LSB = 16;
	localparam int K_LSB = 24;
	localparam int K_W = 7;
	localparam int DATA_LSB = 24;
	// Status word fields
	localparam int ST_BUSY = 0;
	localparam int ST_BAD = 1;
	localparam int ST_CYC_LSB = 8;
	localparam int ST_RES_LSB = 16;
	// Storage sizes
	localparam int GPR_AW = 5;
	localparam int IO_AW = 6;
	localparam int DW = 8;
	localparam int PC_W = 16;
	// Flag positions in processor_flags_register
	localparam int FL_C = 0;
	localparam int FL_Z = 1;
	localparam int FL_N = 2;
	localparam int FL_V = 3;
	localparam int FL_S = 4;
	localparam int FL_H = 5;
	localparam int FL_T = 6;
	localparam int FL_I = 7;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [15:0] PC_STEP = 16'h0001;
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	// Operation codes
	typedef enum logic [4:0] {
		OP_BRANCH_TRANSFER_CLEAR = 5'h00,
		OP_BRANCH_OVERFLOW_SET = 5'h01,
		OP_BRANCH_OVERFLOW_CLEAR = 5'h02,
		OP_BRANCH_IRQ_ENABLED = 5'h03,
		OP_BRANCH_IRQ_DISABLED = 5'h04,
		OP_IO_BIT_SET = 5'h05,
		OP_IO_BIT_CLEAR = 5'h06,
		OP_SHIFT_LEFT_LOGICAL = 5'h07,
		OP_SHIFT_RIGHT_LOGICAL = 5'h08,
		OP_ROTATE_LEFT_CARRY = 5'h09,
		OP_ROTATE_RIGHT_CARRY = 5'h0A,
		OP_SHIFT_RIGHT_ARITH = 5'h0B,
		OP_NIBBLE_SWAP = 5'h0C,
		OP_BIT_TO_TRANSFER_FLAG = 5'h0D,
		OP_TRANSFER_FLAG_TO_BIT = 5'h0E,
		OP_FLAG_SET_INDEXED = 5'h0F,
		OP_FLAG_CLEAR_INDEXED = 5'h10,
		OP_HOST_GPR_WRITE = 5'h11,
		OP_HOST_GPR_READ = 5'h12,
		OP_HOST_IO_WRITE = 5'h13,
		OP_HOST_IO_READ = 5'h14
	} bbf_op_t;
	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_FETCH = 4'h2,
		ST_EXEC = 4'h4,
		ST_EXEC2 = 4'h8
	} bbf_state_t;
endpackage

/* File: include/bbf_mem_if.sv */
`timescale 1ns/1ps
// Single port between the sequencer and a small storage array
interface bbf_mem_if #(parameter int AW = 5, parameter int DW = 8);
	logic [AW-1:0] addr; // Word address, read and write
	logic we; // Write this cycle
	logic [DW-1:0] wdata; // Data to write
	logic [DW-1:0] rdata; // Registered read data
	modport owner (output addr, output we, output wdata, input rdata);
	modport store (input addr, input we, input wdata, output rdata);
endinterface

/* File: hdl/bbf_mem.sv */
`timescale 1ns/1ps
module bbf_mem #(
	parameter int AW = 5,
	parameter int DW = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Access port
	bbf_mem_if.store port
);
	// Storage array, no reset so it maps onto plain RAM
	logic [DW-1:0] mem [0:(2**AW)-1];

	// Write port
	always_ff @(posedge clk) begin
		if (port.we) begin
			mem[port.addr] <= port.wdata;
		end
	end

	// Read-first registered output
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			port.rdata <= '0;
		end else begin
			port.rdata <= mem[port.addr];
		end
	end
endmodule

/* File: testbench/bbf_core_tb_top.sv */
`timescale 1ns/1ps
module bbf_core_tb_top;
	// Bus and clock signals, those the bench drives given a value at time zero
	logic CLK = 1'b0;
	logic ARST_N = 1'b0;
	logic [7:0] AWADDR = 8'h00;
	logic AWVALID = 1'b0;
	logic AWREADY;
	logic [31:0] WDATA = 32'h00000000;
	logic [3:0] WSTRB = 4'hF;
	logic WVALID = 1'b0;
	logic WREADY;
	logic [1:0] BRESP;
	logic BVALID;
	logic BREADY = 1'b1; // Always ready, so responses are never stalled
	logic [7:0] ARADDR = 8'h00;
	logic ARVALID = 1'b0;
	logic ARREADY;
	logic [31:0] RDATA;
	logic [1:0] RRESP;
	logic RVALID;
	logic RREADY = 1'b1;
	// Expected read answer: value, bits compared, response code
	typedef struct packed {
		logic [31:0] data;
		logic [31:0] mask;
		logic [1:0] resp;
	} bbf_exp_t;
	bbf_exp_t rq[$]; // Notes of expected reads, oldest first
	logic [1:0] bq[$]; // Notes of expected write responses
	int fail_count = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [31:0] seed = 32'h00016884; // Xorshift state
	logic [31:0] q; // Last read data

	// Device under test
	bbf_core u_dut (.CLK(CLK), .ARST_N(ARST_N), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
		.BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
		.RREADY(RREADY));

	// 40 MHz clock
	always #12.5 CLK = ~CLK;

	// Verdict, reached from the main sequence or the timeout
	task automatic summarize();
		if (fail_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Read answer compare, masked so poll reads check only the response
	task automatic cmp_r(input bbf_exp_t e);
		n_checks++;
		if ((RDATA & e.mask) !== (e.data & e.mask) || RRESP !== e.resp) begin
			fail_count++;
			$display("MISMATCH %0t read %h exp %h", $time, RDATA, e.data);
		end
	endtask

	// Write response compare
	task automatic cmp_b(input logic [1:0] e);
		n_checks++;
		if (BRESP !== e) begin
			fail_count++;
			$display("MISMATCH %0t bresp %h exp %h", $time, BRESP, e);
		end
	endtask

	// Watcher: takes the oldest note whenever an answer is handed over
	always @(posedge CLK) begin
		if (RVALID === 1'b1 && rq.size() > 0)
			cmp_r(rq.pop_front());
		if (BVALID === 1'b1 && bq.size() > 0)
			cmp_b(bq.pop_front());
	end

	// Hang guard, well above the little over a thousand cycles the run needs
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			summarize();
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Command word: data or k, I/O address, register, bit, opcode
	function automatic logic [31:0] cw(input logic [4:0] op,
		input logic [2:0] b, input logic [4:0] r, input logic [5:0] p,
		input logic [7:0] d);
		return {d, 2'h0, p, 3'h0, r, b, op};
	endfunction

	// Shift result in [15:8], flags in [7:0]; S, H, T, I pass through
	function automatic logic [15:0] shx(input logic [4:0] op,
		input logic [7:0] d, input logic [7:0] f);
		logic lft;
		logic fill;
		logic [7:0] r;
		logic c;
		lft = (op == 5'h07 || op == 5'h09);
		fill = (op == 5'h0B) ? d[7] : ((op == 5'h09 || op == 5'h0A) ?
			f[bbf_pkg::FL_C] : 1'b0);
		r = lft ? {d[6:0], fill} : {fill, d[7:1]};
		c = lft ? d[7] : d[0];
		f[bbf_pkg::FL_C] = c;
		f[bbf_pkg::FL_Z] = (r == 8'h00);
		f[bbf_pkg::FL_N] = r[7];
		f[bbf_pkg::FL_V] = r[7] ^ c;
		return {r, f};
	endfunction

	// Write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] r);
		bit ad;
		bit wd;
		bq.push_back(r);
		ad = 0;
		wd = 0;
		AWADDR <= a;
		AWVALID <= 1'b1;
		WDATA <= d;
		WSTRB <= s;
		WVALID <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge CLK);
			if (!ad && AWREADY === 1'b1) begin
				ad = 1;
				AWVALID <= 1'b0;
			end
			if (!wd && WREADY === 1'b1) begin
				wd = 1;
				WVALID <= 1'b0;
			end
		end
		do @(posedge CLK); while (BVALID !== 1'b1);
	endtask

	// Read: note the expectation, then hold the request until taken
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m, input logic [1:0] r);
		rq.push_back('{e, m, r});
		ARADDR <= a;
		ARVALID <= 1'b1;
		do @(posedge CLK); while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		do @(posedge CLK); while (RVALID !== 1'b1);
		q = RDATA;
	endtask

	task automatic st(input logic [31:0] e, input logic [31:0] m);
		rd(bbf_pkg::OFS_STATUS, e, m, bbf_pkg::RESP_OKAY);
	endtask

	task automatic fl(input logic [7:0] e);
		rd(bbf_pkg::OFS_FLAGS, {24'h000000, e}, 32'h000000FF,
			bbf_pkg::RESP_OKAY);
	endtask

	task automatic wf(input logic [7:0] f);
		wr(bbf_pkg::OFS_FLAGS, {24'h000000, f}, 4'hF, bbf_pkg::RESP_OKAY);
	endtask

	// Start a command and poll busy until it clears
	task automatic run(input logic [31:0] w);
		wr(bbf_pkg::OFS_CMD, w, 4'hF, bbf_pkg::RESP_OKAY);
		do st(32'h00000000, 32'h00000000); while (q[bbf_pkg::ST_BUSY] !== 1'b0);
	endtask

	// Main sequence
	initial begin
		logic [7:0] d;
		logic [7:0] f;
		logic [7:0] e8;
		logic [15:0] e;
		logic [15:0] pc;
		logic [7:0] k;
		logic [4:0] rg;
		logic [5:0] p;
		logic [2:0] b;
		int bt;
		repeat (3) @(posedge CLK);
		ARST_N <= 1'b1;
		@(posedge CLK);
		// Reset state, unmapped place and byte-strobe merge
		rd(bbf_pkg::OFS_PC, 32'h0, 32'h0000FFFF, bbf_pkg::RESP_OKAY);
		fl(bbf_pkg::FLAGS_RST);
		rd(8'h10, 32'h0, 32'hFFFFFFFF, bbf_pkg::RESP_SLVERR);
		wr(8'h10, rnd(), 4'hF, bbf_pkg::RESP_SLVERR);
		wr(bbf_pkg::OFS_PC, 32'h00001234, 4'hF, bbf_pkg::RESP_OKAY);
		wr(bbf_pkg::OFS_PC, 32'h0000ABCD, 4'h1, bbf_pkg::RESP_OKAY);
		rd(bbf_pkg::OFS_PC, 32'h12CD, 32'hFFFF, bbf_pkg::RESP_OKAY);
		for (int op = 7; op <= 12; op++) begin
			repeat (3) begin
				d = 8'(rnd());
				f = 8'(rnd());
				rg = 5'(rnd());
				wf(f);
				run(cw(bbf_pkg::OP_HOST_GPR_WRITE, 3'h0, rg, 6'h00, d));
				run(cw(op[4:0], 3'h0, rg, 6'h00, 8'h00));
				e = (op == 12) ? {d[3:0], d[7:4], f} : shx(op[4:0], d, f);
				st({22'h0, bbf_pkg::CYC_ONE, 8'h00}, 32'h00000300);
				fl(e[7:0]);
				run(cw(bbf_pkg::OP_HOST_GPR_READ, 3'h0, rg, 6'h00, 8'h00));
				st({8'h00, e[15:8], 16'h0}, 32'h00FF0000);
			end
		end
		for (int op = 0; op <= 4; op++) begin
			for (int t = 0; t <= 1; t++) begin
				bt = (op == 0) ? bbf_pkg::FL_T : ((op < 3) ? bbf_pkg::FL_V :
					bbf_pkg::FL_I);
				f = 8'(rnd());
				f[bt] = (t == 1) ~^ (op == 1 || op == 3);
				pc = 16'(rnd());
				k = 8'(rnd());
				wf(f);
				wr(bbf_pkg::OFS_PC, {16'h0, pc}, 4'hF, bbf_pkg::RESP_OKAY);
				run(cw(op[4:0], 3'h0, 5'h00, 6'h00, {1'b0, k[6:0]}));
				e = pc + 16'h0001 + ((t == 1) ? {{9{k[6]}}, k[6:0]} : 16'h0);
				rd(bbf_pkg::OFS_PC, {16'h0, e}, 32'hFFFF, 2'h0);
				st({22'h0, (t == 1) ? bbf_pkg::CYC_TWO : bbf_pkg::CYC_ONE,
					8'h00}, 32'h00000300);
				fl(f);
			end
		end
		for (int t = 0; t <= 1; t++) begin
			p = 6'(rnd());
			d = 8'(rnd());
			b = 3'(rnd());
			f = 8'(rnd());
			run(cw(bbf_pkg::OP_HOST_IO_WRITE, 3'h0, 5'h00, p, d));
			wf(f);
			run(cw((t == 1) ? bbf_pkg::OP_IO_BIT_CLEAR : bbf_pkg::OP_IO_BIT_SET,
				b, 5'h00, p, 8'h00));
			st({22'h0, bbf_pkg::CYC_TWO, 8'h00}, 32'h00000300);
			fl(f);
			run(cw(bbf_pkg::OP_HOST_IO_READ, 3'h0, 5'h00, p, 8'h00));
			e8 = d;
			e8[b] = (t == 0);
			st({8'h00, e8, 16'h0}, 32'h00FF0000);
		end
		// bit moves through the transfer flag
		repeat (4) begin
			d = 8'(rnd());
			f = 8'(rnd());
			b = 3'(rnd());
			rg = 5'(rnd());
			run(cw(bbf_pkg::OP_HOST_GPR_WRITE, 3'h0, rg, 6'h00, d));
			wf(f);
			run(cw(bbf_pkg::OP_BIT_TO_TRANSFER_FLAG, b, rg, 6'h00, 8'h00));
			f[bbf_pkg::FL_T] = d[b];
			fl(f);
			b = b + 3'h1;
			run(cw(bbf_pkg::OP_TRANSFER_FLAG_TO_BIT, b, rg, 6'h00, 8'h00));
			fl(f);
			d[b] = f[bbf_pkg::FL_T];
			run(cw(bbf_pkg::OP_HOST_GPR_READ, 3'h0, rg, 6'h00, 8'h00));
			st({8'h00, d, 16'h0}, 32'h00FF0000);
		end
		// every flag index set and cleared
		for (int s = 0; s < 8; s++) begin
			f = 8'(rnd());
			wf(f);
			run(cw(bbf_pkg::OP_FLAG_SET_INDEXED, s[2:0], 5'h00, 6'h00, 8'h00));
			f[s] = 1'b1;
			fl(f);
			run(cw(bbf_pkg::OP_FLAG_CLEAR_INDEXED, s[2:0], 5'h00, 6'h00, 8'h00));
			f[s] = 1'b0;
			fl(f);
		end
		// Unknown opcode: flagged, PC and flags left alone
		wr(bbf_pkg::OFS_PC, 32'h00000055, 4'hF, bbf_pkg::RESP_OKAY);
		run(cw(5'h1F, 3'h0, 5'h00, 6'h00, 8'h00));
		st(32'h00000002, 32'h00000002);
		rd(bbf_pkg::OFS_PC, 32'h55, 32'hFFFF, bbf_pkg::RESP_OKAY);
		fl(f);
		// Command word reads back, status writes are ignored
		rd(bbf_pkg::OFS_CMD, 32'h0000001F, 32'hFFFFFFFF, bbf_pkg::RESP_OKAY);
		wr(bbf_pkg::OFS_STATUS, 32'h0, 4'hF, bbf_pkg::RESP_OKAY);
		st(32'h00000002, 32'h00000002);
		// Let the watcher take the last answer before the verdict
		repeat (2) @(posedge CLK);
		if (rq.size() != 0 || bq.size() != 0) begin
			fail_count++;
			$display("MISMATCH %0t answers missing", $time);
		end
		summarize();
	end
endmodule
